/* File: pci_master_termination.sv */
`timescale 1ns/1ps
module pci_master_termination (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RSTN,
  input  wire pcim_pkg::xfer_req_s  XFER,
  output logic                      XFER_BUSY,
  output logic                      XFER_DONE,
  output logic                      WORD_ACK,
  input  wire pcim_pkg::mbus_in_s   BUS_IN,
  output pcim_pkg::mbus_out_s       BUS_OUT,
  output pcim_pkg::abort_ev_s       ABORT_EV,
  output logic [15:0]               ETH_CFG_STATUS,
  input  wire logic [15:0]          ETH_CFG_STATUS_CLR,
  output logic [15:0]               SCSI_CFG_STATUS,
  input  wire logic [15:0]          SCSI_CFG_STATUS_CLR,
  output logic [7:0]                SCSI_DMA_STATUS,
  input  wire logic [7:0]           SCSI_DMA_STATUS_CLR,
  output logic [7:0]                LATENCY_TIMER
);

  localparam logic [2:0] MA_LAST = 3'(pcim_pkg::MA_CLOCKS - 1);
  localparam logic [1:0] GAP_END = 2'(pcim_pkg::RETRY_GAP - 2);
  localparam logic [pcim_pkg::XFER_CNT_W-1:0] ONE_WORD = {{(pcim_pkg::XFER_CNT_W-1){1'b0}}, 1'b1};

  pcim_pkg::mst_state_e             state_r,     state_nxt;
  pcim_pkg::end_why_e               why_r,       why_nxt;
  pcim_pkg::mbus_out_s              bus_r,       bus_nxt;
  pcim_pkg::abort_ev_s              ev_r,        ev_nxt;
  logic [31:0]                      addr_r,      addr_nxt;
  logic [pcim_pkg::XFER_CNT_W-1:0]  left_r,      left_nxt;
  logic                             scsi_r,      scsi_nxt;
  logic                             wr_r,        wr_nxt;
  logic                             burst_r,     burst_nxt;
  logic                             mabort_r,    mabort_nxt;
  logic                             seen_r,      seen_nxt;
  logic [2:0]                       macnt_r,     macnt_nxt;
  logic [1:0]                       gap_r,       gap_nxt;
  logic                             busy_r,      busy_nxt;
  logic                             done_r,      done_nxt;
  logic                             ack_r,       ack_nxt;
  logic [15:0]                      eth_stat_r,  eth_stat_nxt;
  logic [15:0]                      scsi_stat_r, scsi_stat_nxt;
  logic [7:0]                       dma_stat_r,  dma_stat_nxt;
  logic [7:0]                       lat_r;
  logic                             dev;
  logic                             stp;
  logic                             rdy;
  logic                             gnt;
  logic [15:0]                      eth_set;
  logic [15:0]                      scsi_set;
  logic [7:0]                       dma_set;

  assign dev = !BUS_IN.devsel_n;
  assign stp = !BUS_IN.stop_n;
  assign rdy = !BUS_IN.trdy_n;
  assign gnt = !BUS_IN.gnt_n;

  always_comb begin
    state_nxt  = state_r;
    why_nxt    = why_r;
    bus_nxt    = bus_r;
    addr_nxt   = addr_r;
    left_nxt   = left_r;
    scsi_nxt   = scsi_r;
    wr_nxt     = wr_r;
    burst_nxt  = burst_r;
    mabort_nxt = mabort_r;
    seen_nxt   = seen_r;
    macnt_nxt  = macnt_r;
    gap_nxt    = gap_r;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    ack_nxt    = 1'b0;
    ev_nxt     = '0;
    eth_set    = '0;
    scsi_set   = '0;
    dma_set    = '0;
    case (state_r)
      pcim_pkg::ST_IDLE: begin
        // a start while busy is ignored: the engine waits for done
        if (XFER.start && (XFER.words != '0)) begin
          addr_nxt      = XFER.addr;
          left_nxt      = XFER.words;
          scsi_nxt      = XFER.func_scsi;
          wr_nxt        = XFER.write;
          burst_nxt     = XFER.burst;
          busy_nxt      = 1'b1;
          bus_nxt.req_n = 1'b0;
          state_nxt     = pcim_pkg::ST_REQ;
        end
      end
      pcim_pkg::ST_REQ: begin
        bus_nxt.req_n = 1'b0;
        if (gnt) begin
          state_nxt = pcim_pkg::ST_ADDR;
        end
      end
      pcim_pkg::ST_DATA: begin
        seen_nxt = seen_r | dev;
        if (macnt_r != MA_LAST) begin
          macnt_nxt = macnt_r + 3'h1;
        end
        if (stp && !dev && seen_r) begin
          mabort_nxt = 1'b0;
          why_nxt    = pcim_pkg::W_FATAL;
          state_nxt  = pcim_pkg::ST_END1;
        end else if (!dev && !seen_r && (macnt_r == MA_LAST)) begin
          mabort_nxt = 1'b1;
          why_nxt    = pcim_pkg::W_FATAL;
          state_nxt  = pcim_pkg::ST_END1;
        end else if (dev && rdy) begin
          ack_nxt  = 1'b1;
          addr_nxt = addr_r + pcim_pkg::ADDR_STEP;
          left_nxt = left_r - ONE_WORD;
          if (left_r == ONE_WORD) begin
            why_nxt   = pcim_pkg::W_DONE;
            state_nxt = pcim_pkg::ST_END1;
          end else if (stp) begin
            why_nxt   = pcim_pkg::W_RETRY;
            state_nxt = pcim_pkg::ST_END1;
          end else if (!gnt) begin
            // grant may vanish at any moment; finish this word only
            why_nxt   = pcim_pkg::W_PREEMPT;
            state_nxt = pcim_pkg::ST_END1;
          end else if (!burst_r) begin
            why_nxt   = pcim_pkg::W_NEXT;
            state_nxt = pcim_pkg::ST_END1;
          end
        end else if (dev && stp) begin
          why_nxt   = pcim_pkg::W_RETRY;
          state_nxt = pcim_pkg::ST_END1;
        end
        if (state_nxt == pcim_pkg::ST_END1) begin
          bus_nxt.frame_n = 1'b1;
          bus_nxt.ad_oe   = 1'b0;
          bus_nxt.cbe_oe  = 1'b0;
          bus_nxt.req_n   = !((why_nxt == pcim_pkg::W_PREEMPT) ||
                              (why_nxt == pcim_pkg::W_NEXT));
        end
      end
      pcim_pkg::ST_ADDR: begin
        bus_nxt.irdy_n = 1'b0;
        bus_nxt.ad_oe  = wr_r;
        bus_nxt.cbe    = pcim_pkg::BE_ALL_ON;
        state_nxt      = pcim_pkg::ST_DATA;
      end
      pcim_pkg::ST_END1: begin
        bus_nxt.irdy_n = 1'b1;
        state_nxt      = pcim_pkg::ST_END2;
      end
      pcim_pkg::ST_END2: begin
        // idle cycle on the bus: both frame and irdy are high here
        bus_nxt.frame_oe = 1'b0;
        bus_nxt.irdy_oe  = 1'b0;
        case (why_r)
          pcim_pkg::W_NEXT: begin
            state_nxt = gnt ? pcim_pkg::ST_ADDR : pcim_pkg::ST_REQ;
          end
          pcim_pkg::W_PREEMPT: begin
            state_nxt = pcim_pkg::ST_REQ;
          end
          pcim_pkg::W_RETRY: begin
            gap_nxt   = '0;
            state_nxt = pcim_pkg::ST_BACKOFF;
          end
          pcim_pkg::W_FATAL: begin
            busy_nxt  = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = pcim_pkg::ST_IDLE;
            if (scsi_r) begin
              // no interrupt line is touched; only the status bits and the scsi abort pulse move
              ev_nxt.scsi_tabort = !mabort_r;
              ev_nxt.scsi_mabort = mabort_r;
              dma_set[pcim_pkg::DMA_STAT_ABORT_BIT] = 1'b1;
              scsi_set[pcim_pkg::CFG_STAT_RTA_BIT]  = !mabort_r;
              scsi_set[pcim_pkg::CFG_STAT_RMA_BIT]  = mabort_r;
            end else begin
              ev_nxt.eth_tabort     = !mabort_r;
              ev_nxt.eth_mabort     = mabort_r;
              ev_nxt.eth_regs_reset = 1'b1;
              ev_nxt.net_halt       = 1'b1;
              eth_set[pcim_pkg::CFG_STAT_RTA_BIT] = !mabort_r;
              eth_set[pcim_pkg::CFG_STAT_RMA_BIT] = mabort_r;
            end
          end
          default: begin
            busy_nxt  = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = pcim_pkg::ST_IDLE;
          end
        endcase
      end
      pcim_pkg::ST_BACKOFF: begin
        gap_nxt = gap_r + 2'h1;
        if (gap_r == GAP_END) begin
          bus_nxt.req_n = 1'b0;
          state_nxt     = pcim_pkg::ST_REQ;
        end
      end
      default: begin
        state_nxt = pcim_pkg::ST_IDLE;
      end
    endcase
    if (state_nxt == pcim_pkg::ST_ADDR) begin
      // restart drives addr_nxt, which equals addr_r here, so a retry repeats the unmoved word
      bus_nxt.frame_n  = 1'b0;
      bus_nxt.frame_oe = 1'b1;
      bus_nxt.irdy_n   = 1'b1;
      bus_nxt.irdy_oe  = 1'b1;
      bus_nxt.ad       = addr_nxt;
      bus_nxt.ad_oe    = 1'b1;
      bus_nxt.cbe_oe   = 1'b1;
      bus_nxt.cbe      = wr_r ? pcim_pkg::CMD_MEM_WR :
                         (burst_r ? pcim_pkg::CMD_MEM_RD_LINE : pcim_pkg::CMD_MEM_RD);
      seen_nxt         = 1'b0;
      macnt_nxt        = '0;
    end
    // set wins over a clear landing in the same cycle
    eth_stat_nxt  = (eth_stat_r & ~ETH_CFG_STATUS_CLR) | eth_set;
    scsi_stat_nxt = (scsi_stat_r & ~SCSI_CFG_STATUS_CLR) | scsi_set;
    dma_stat_nxt  = (dma_stat_r & ~SCSI_DMA_STATUS_CLR) | dma_set;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_r       <= pcim_pkg::ST_IDLE;
      why_r         <= pcim_pkg::W_DONE;
      bus_r         <= '{req_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1, default: '0};
      ev_r          <= '0;
      addr_r        <= '0;
      left_r        <= '0;
      scsi_r        <= 1'b0;
      wr_r          <= 1'b0;
      burst_r       <= 1'b0;
      mabort_r      <= 1'b0;
      seen_r        <= 1'b0;
      macnt_r       <= '0;
      gap_r         <= '0;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      ack_r         <= 1'b0;
      eth_stat_r    <= '0;
      scsi_stat_r   <= '0;
      dma_stat_r    <= '0;
      lat_r         <= pcim_pkg::LAT_TIMER_VAL;
    end else begin
      state_r       <= state_nxt;
      why_r         <= why_nxt;
      bus_r         <= bus_nxt;
      ev_r          <= ev_nxt;
      addr_r        <= addr_nxt;
      left_r        <= left_nxt;
      scsi_r        <= scsi_nxt;
      wr_r          <= wr_nxt;
      burst_r       <= burst_nxt;
      mabort_r      <= mabort_nxt;
      seen_r        <= seen_nxt;
      macnt_r       <= macnt_nxt;
      gap_r         <= gap_nxt;
      busy_r        <= busy_nxt;
      done_r        <= done_nxt;
      ack_r         <= ack_nxt;
      eth_stat_r    <= eth_stat_nxt;
      scsi_stat_r   <= scsi_stat_nxt;
      dma_stat_r    <= dma_stat_nxt;
      lat_r         <= pcim_pkg::LAT_TIMER_VAL;
    end
  end

  assign BUS_OUT         = bus_r;
  assign ABORT_EV        = ev_r;
  assign XFER_BUSY       = busy_r;
  assign XFER_DONE       = done_r;
  assign WORD_ACK        = ack_r;
  assign ETH_CFG_STATUS  = eth_stat_r;
  assign SCSI_CFG_STATUS = scsi_stat_r;
  assign SCSI_DMA_STATUS = dma_stat_r;
  assign LATENCY_TIMER   = lat_r;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_frame_then_irdy: assert property (
    (state_r == pcim_pkg::ST_DATA) && (state_nxt == pcim_pkg::ST_END1)
    |=> bus_r.frame_n && !bus_r.irdy_n ##1 bus_r.frame_n && bus_r.irdy_n)
    else $error("frame and irdy not dropped in order");

  a_retry_gap: assert property (
    (state_r == pcim_pkg::ST_END2) && (why_r == pcim_pkg::W_RETRY)
    |-> bus_r.req_n [*2] ##1 !bus_r.req_n)
    else $error("retry request not two clocks after release");

  a_retry_same_addr: assert property (
    (state_r == pcim_pkg::ST_DATA) && dev && stp && !rdy
    |=> addr_r == $past(addr_r))
    else $error("no-data disconnect moved the address");

  a_tabort_no_retry: assert property (
    ev_r.eth_tabort || ev_r.scsi_tabort
    |-> (state_r == pcim_pkg::ST_IDLE) && bus_r.req_n && !busy_r)
    else $error("target abort followed by a retry");

  a_eth_fatal: assert property (
    ev_r.eth_tabort || ev_r.eth_mabort |-> ev_r.eth_regs_reset && ev_r.net_halt)
    else $error("ethernet abort without register reset and halt");

  a_scsi_abort_bit: assert property (
    ev_r.scsi_tabort || ev_r.scsi_mabort
    |-> dma_stat_r[pcim_pkg::DMA_STAT_ABORT_BIT] && !ev_r.eth_regs_reset)
    else $error("scsi abort did not set dma abort bit");

  a_rta_flag: assert property (
    ev_r.eth_tabort |-> eth_stat_r[pcim_pkg::CFG_STAT_RTA_BIT])
    else $error("target abort flag not set");

  a_rma_flag: assert property (
    ev_r.scsi_mabort |-> scsi_stat_r[pcim_pkg::CFG_STAT_RMA_BIT])
    else $error("master abort flag not set");

  a_preempt_req: assert property (
    (state_r == pcim_pkg::ST_END1) && (why_r == pcim_pkg::W_PREEMPT)
    |-> !bus_r.req_n [*3])
    else $error("request dropped after preemption");

  a_lat_zero: assert property (
    LATENCY_TIMER == pcim_pkg::LAT_TIMER_VAL)
    else $error("latency timer not zero");

  a_master_abort: assert property (
    $rose(state_r == pcim_pkg::ST_DATA) ##0 (!dev && !stp) [*4]
    |=> (state_r == pcim_pkg::ST_END1) && mabort_r)
    else $error("no master abort after four clocks");

  a_idle_end: assert property (
    $fell(busy_r) |-> $past(bus_r.frame_n) && $past(bus_r.irdy_n))
    else $error("transfer ended without idle bus");

  a_pulse_once: assert property (
    ev_r.eth_mabort || ev_r.scsi_mabort || ev_r.eth_tabort || ev_r.scsi_tabort
    |=> ev_r == '0)
    else $error("abort indication longer than one cycle");

  c_retry:   cover property ((state_r == pcim_pkg::ST_BACKOFF) ##1 !bus_r.req_n);
  c_tabort:  cover property (ev_r.eth_tabort);
  c_mabort:  cover property (ev_r.scsi_mabort);
  c_preempt: cover property ((why_r == pcim_pkg::W_PREEMPT) && (state_r == pcim_pkg::ST_END2));

endmodule

/* File: pcim_far_side.sv */
`timescale 1ns/1ps
module pcim_far_side (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire pcim_pkg::mbus_out_s bus_out,
  input  wire logic [2:0]          mode,
  input  wire logic                arm,
  input  wire logic [1:0]          dsel,
  input  wire logic [1:0]          waits,
  output pcim_pkg::mbus_in_s       bus_in
);
  // mode 0 plain, 1 nobody claims, 2 target abort, 3 stop no data,
  // 4 stop with data, 5 grant pulled; armed once, later cycles answer plainly
  typedef struct packed {
    logic [2:0] pend;
    logic [2:0] cur;
    logic [2:0] hold;
    logic [3:0] k;
    logic [1:0] wc;
    logic       act;
    logic       gnt;
  } far_s;

  far_s st_r, st_nxt;
  logic adr, dev, trd, stp;

  always_comb begin
    adr = bus_out.frame_oe & ~bus_out.frame_n & bus_out.irdy_n;
    dev = 1'b0;
    trd = 1'b0;
    stp = 1'b0;
    case (st_r.cur)
      3'h1: dev = 1'b0;
      3'h2: begin
        dev = (st_r.k == 4'h1);
        stp = (st_r.k >= 4'h2);
      end
      3'h3: begin
        dev = 1'b1;
        stp = (st_r.k >= 4'h2);
      end
      3'h4: begin
        dev = 1'b1;
        trd = (st_r.k == 4'h1);
        stp = 1'b1;
      end
      default: begin
        dev = (st_r.k >= {2'h0, dsel});
        trd = dev & (st_r.wc == waits);
      end
    endcase
    st_nxt = st_r;
    st_nxt.pend = arm ? mode : st_r.pend;
    st_nxt.hold = (st_r.hold != 3'h0) ? st_r.hold - 3'h1 : 3'h0;
    if (adr) begin
      st_nxt.cur = st_r.pend;
      st_nxt.pend = 3'h0;
      st_nxt.k = 4'h1;
      st_nxt.wc = 2'h0;
      st_nxt.act = 1'b1;
      st_nxt.hold = (st_r.pend == 3'h5) ? 3'h6 : 3'h0;
    end else if (st_r.act) begin
      // target lets go once frame is seen high; the idle cycle is the master's
      st_nxt.act = ~bus_out.frame_n;
      st_nxt.k = (st_r.k == 4'hF) ? st_r.k : st_r.k + 4'h1;
      if (dev)
        st_nxt.wc = (st_r.wc == waits) ? 2'h0 : st_r.wc + 2'h1;
    end
    // grant may vanish mid-transfer, regardless of what the master is doing
    st_nxt.gnt = (st_nxt.hold != 3'h0) | bus_out.req_n;
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      st_r <= '{pend: 3'h0, cur: 3'h0, hold: 3'h0, k: 4'h0, wc: 2'h0, act: 1'b0, gnt: 1'b1};
    else
      st_r <= st_nxt;
  end

  // released control lines return to their pull-ups
  assign bus_in.gnt_n    = st_r.gnt;
  assign bus_in.devsel_n = ~(st_r.act & dev);
  assign bus_in.trdy_n   = ~(st_r.act & trd);
  assign bus_in.stop_n   = ~(st_r.act & stp);
endmodule

/* File: pcim_pkg.sv */
package pcim_pkg;

  localparam logic [3:0]  CMD_MEM_RD        = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR        = 4'h7;
  localparam logic [3:0]  CMD_MEM_RD_LINE   = 4'hE;
  localparam logic [3:0]  BE_ALL_ON         = 4'h0;
  localparam logic [31:0] ADDR_STEP         = 32'h0000_0004;
  localparam int          XFER_CNT_W        = 16;
  localparam int          MA_CLOCKS         = 4;
  localparam int          RETRY_GAP         = 2;
  localparam int          CFG_STAT_RTA_BIT  = 12;
  localparam int          CFG_STAT_RMA_BIT  = 13;
  localparam int          DMA_STAT_ABORT_BIT = 2;
  localparam logic [7:0]  LAT_TIMER_VAL     = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_REQ     = 3'b001,
    ST_ADDR    = 3'b010,
    ST_DATA    = 3'b011,
    ST_END1    = 3'b100,
    ST_END2    = 3'b101,
    ST_BACKOFF = 3'b110
  } mst_state_e;

  typedef enum logic [2:0] {
    W_DONE    = 3'b000,
    W_NEXT    = 3'b001,
    W_PREEMPT = 3'b010,
    W_RETRY   = 3'b011,
    W_FATAL   = 3'b100
  } end_why_e;

  typedef struct packed {
    logic                  start;
    logic                  func_scsi;
    logic                  write;
    logic                  burst;
    logic [31:0]           addr;
    logic [XFER_CNT_W-1:0] words;
  } xfer_req_s;

  typedef struct packed {
    logic gnt_n;
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
  } mbus_in_s;

  typedef struct packed {
    logic        req_n;
    logic        frame_n;
    logic        frame_oe;
    logic        irdy_n;
    logic        irdy_oe;
    logic [31:0] ad;
    logic        ad_oe;
    logic [3:0]  cbe;
    logic        cbe_oe;
  } mbus_out_s;

  typedef struct packed {
    logic eth_tabort;
    logic eth_mabort;
    logic scsi_tabort;
    logic scsi_mabort;
    logic eth_regs_reset;
    logic net_halt;
  } abort_ev_s;

endpackage

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] M_OK = 3'h0, M_NODEV = 3'h1, M_TABT = 3'h2, M_DISC0 = 3'h3;
  localparam logic [2:0] M_DISC1 = 3'h4, M_PRE = 3'h5;
  logic                sys_clk, rstn, busy, done, ack, arm;
  pcim_pkg::xfer_req_s xfer;
  pcim_pkg::mbus_in_s  bin;
  pcim_pkg::mbus_out_s bout;
  pcim_pkg::abort_ev_s aev;
  logic [15:0]         eth_st, eth_clr, scsi_st, scsi_clr;
  logic [7:0]          dma_st, dma_clr, lat, hi_cnt, gap, len, wcnt;
  logic [2:0]          mode;
  logic [1:0]          dsel, waits;
  logic                pf, pi, pstop;
  logic [43:0]         pe, ph_q[$];
  logic [31:0]         de, dn_q[$];
  int                  err_total, cmp_count;
  integer              seed = 32'h8EF9;

  pci_master_termination dut (.SYS_CLK(sys_clk), .RSTN(rstn), .XFER(xfer), .XFER_BUSY(busy),
    .XFER_DONE(done), .WORD_ACK(ack), .BUS_IN(bin), .BUS_OUT(bout), .ABORT_EV(aev),
    .ETH_CFG_STATUS(eth_st), .ETH_CFG_STATUS_CLR(eth_clr), .SCSI_CFG_STATUS(scsi_st),
    .SCSI_CFG_STATUS_CLR(scsi_clr), .SCSI_DMA_STATUS(dma_st),
    .SCSI_DMA_STATUS_CLR(dma_clr), .LATENCY_TIMER(lat));
  pcim_far_side far (.clk(sys_clk), .rst_n(rstn), .bus_out(bout), .mode(mode), .arm(arm),
    .dsel(dsel), .waits(waits), .bus_in(bin));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_phase(input logic [43:0] e, input logic [43:0] g);
    report("address phase", 64'(e), 64'(g));
  endtask
  task automatic chk_done(input logic [31:0] e, input logic [31:0] g);
    report("transfer end", 64'(e), 64'(g));
  endtask
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    report(nm, 64'(e), 64'(g));
  endtask
  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // notes every address phase and the end record, then drives one request;
  // the request drops together with frame, so a retry gap counts one clock more
  task automatic run(input logic scsi, input logic wr, input logic bst, input logic [2:0] m);
    logic [31:0] a;
    logic [15:0] n;
    logic [1:0]  kd;
    logic [3:0]  cbe;
    logic [5:0]  ev;
    integer      i;
    a = $random(seed) & 32'hFFFF_FFFC;
    n = (m == M_OK) ? 16'(1 + ({$random(seed)} % 4)) : 16'h0003;
    dsel = (m == M_PRE) ? 2'h1 : 2'({$random(seed)} % 3) + 2'h1;
    waits = (m == M_PRE) ? 2'h2 : 2'({$random(seed)} % 3);
    kd = (m == M_TABT) ? 2'h1 : (m == M_NODEV) ? 2'h2 : 2'h0;
    cbe = wr ? pcim_pkg::CMD_MEM_WR : bst ? pcim_pkg::CMD_MEM_RD_LINE : pcim_pkg::CMD_MEM_RD;
    ph_q.push_back({8'hFF, cbe, a});
    if (kd == 2'h0 && !bst)
      for (i = 1; i < n; i++)
        ph_q.push_back({(m == M_PRE && i == 1) ? 8'h00 : 8'hFF, cbe,
                        a + 32'(i) * pcim_pkg::ADDR_STEP});
    else if (m == M_DISC0)
      ph_q.push_back({8'(pcim_pkg::RETRY_GAP + 1), cbe, a});
    else if (m == M_DISC1 || m == M_PRE)
      ph_q.push_back({(m == M_PRE) ? 8'h00 : 8'(pcim_pkg::RETRY_GAP + 1), cbe,
                      a + pcim_pkg::ADDR_STEP});
    ev = scsi ? {2'b00, kd == 2'h1, kd == 2'h2, 2'b00}
              : {kd == 2'h1, kd == 2'h2, 2'b00, {2{kd != 2'h0}}};
    dn_q.push_back({(kd == 2'h2) ? 8'(pcim_pkg::MA_CLOCKS + 1) : 8'hFF,
                    (kd != 2'h0) ? 8'h00 : n[7:0], ev,
                    scsi ? 2'b00 : {kd == 2'h2, kd == 2'h1},
                    scsi ? {kd == 2'h2, kd == 2'h1} : 2'b00, scsi & (kd != 2'h0), 5'h00});
    @(negedge sys_clk);
    eth_clr = 16'hFFFF;
    scsi_clr = 16'hFFFF;
    dma_clr = 8'hFF;
    mode = m;
    arm = 1'b1;
    @(negedge sys_clk);
    eth_clr = 16'h0000;
    scsi_clr = 16'h0000;
    dma_clr = 8'h00;
    arm = 1'b0;
    xfer = '{1'b1, scsi, wr, bst, a, n};
    @(negedge sys_clk);
    xfer.start = 1'b0;
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge sys_clk);
    if (i == 400) report("done timeout", 64'h1, 64'h0);
    repeat (3) @(negedge sys_clk);
  endtask

  initial begin
    int s, c, m;
    rstn = 1'b0;
    xfer = '0;
    eth_clr = 16'h0000;
    scsi_clr = 16'h0000;
    dma_clr = 8'h00;
    mode = M_OK;
    arm = 1'b0;
    dsel = 2'h1;
    waits = 2'h0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    for (s = 0; s < 2; s++)
      for (c = 0; c < 4; c++) run(s[0], c[0], c[1], M_OK);
    for (m = 1; m < 6; m++)
      for (s = 0; s < 2; s++)
        run(s[0], 1'($random(seed)), (m == 3 || m == 4) ? 1'b1 : (m == 5) ? s[0]
            : 1'($random(seed)), 3'(m));
    report("phases left", 64'h0, 64'(ph_q.size()));
    report("ends left", 64'h0, 64'(dn_q.size()));
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end

  // watches the bus and the engine side; gap is how long the request was dropped
  always @(posedge sys_clk) begin
    if (!rstn) begin
      {hi_cnt, gap, len, wcnt} = 32'h0000_0000;
      {pf, pi, pstop} = 3'b110;
    end else begin
      if (bout.req_n) hi_cnt = (hi_cnt == 8'hFE) ? hi_cnt : hi_cnt + 8'h01;
      else if (hi_cnt != 8'h00) begin
        gap = hi_cnt;
        hi_cnt = 8'h00;
      end
      if (!bout.frame_n) len = len + 8'h01;
      if (pstop) chk_val("frame after stop", 8'h01, 8'(bout.frame_n));
      if (!pf && bout.frame_n) chk_val("irdy at frame end", 8'h00, 8'(bout.irdy_n));
      if (!pi && bout.irdy_n) chk_val("frame before irdy", 8'h01, 8'(pf));
      if (pf && bout.frame_oe && !bout.frame_n) begin
        pe = (ph_q.size() != 0) ? ph_q.pop_front() : '1;
        chk_phase(pe, {(pe[43:36] == 8'hFF) ? 8'hFF : gap, bout.cbe, bout.ad});
        gap = 8'h00;
        len = 8'h01;
      end
      if (ack) begin
        wcnt = wcnt + 8'h01;
        chk_val("busy in transfer", 8'h01, 8'(busy));
      end
      if (done) begin
        de = (dn_q.size() != 0) ? dn_q.pop_front() : '1;
        chk_done(de, {(de[31:24] == 8'hFF) ? 8'hFF : len, wcnt, aev,
                      eth_st[pcim_pkg::CFG_STAT_RMA_BIT], eth_st[pcim_pkg::CFG_STAT_RTA_BIT],
                      scsi_st[pcim_pkg::CFG_STAT_RMA_BIT], scsi_st[pcim_pkg::CFG_STAT_RTA_BIT],
                      dma_st[pcim_pkg::DMA_STAT_ABORT_BIT], 5'h00});
        chk_val("latency timer", pcim_pkg::LAT_TIMER_VAL, lat);
        chk_val("busy and enables at end", 8'h00,
                8'({busy, bout.frame_oe, bout.irdy_oe, bout.ad_oe, bout.cbe_oe}));
        wcnt = 8'h00;
      end else chk_val("abort pulse", 8'h00, 8'(aev));
      pf = bout.frame_n;
      pi = bout.irdy_n;
      pstop = !bin.stop_n && !bout.frame_n;
    end
  end
endmodule
